// ### pif_cfg.svh
`ifndef PIF_CFG_SVH
`define PIF_CFG_SVH
`define PIF_OFF_ENABLE2 12'h000
`define PIF_OFF_FLAGS1 12'h004
`define PIF_OFF_FLAGS2 12'h008
`define PIF_OFF_CONTROL 12'h00c
`define PIF_RST_ENABLE2 8'h00
`define PIF_RST_FLAGS1 8'h00
`define PIF_RST_FLAGS2 8'h00
`define PIF_RST_CONTROL 8'h00
`define PIF_MASK_ENABLE2 8'hfd
`define PIF_MASK_FLAGS1 8'h7f
`define PIF_MASK_FLAGS2 8'hfd
`define PIF_MASK_FLAGS1_SW 8'h4f
`define PIF_BIT_RX_FULL 5
`define PIF_BIT_TX_EMPTY 4
`define PIF_BIT_GROUP_EN 6
`define PIF_BIT_GLOBAL_EN 7
`endif

// ### pif_pkg.sv
package pif_pkg;
  typedef struct packed {
    logic [7:0] enable2;
    logic [7:0] flags1_sw;
    logic [7:0] flags2;
    logic [7:0] control;
    logic [31:0] prdata;
    logic [1:0] cmp_out;
  } pif_state_t;
  typedef struct packed {
    logic conversion_done;
    logic sync_serial_done;
    logic capcmp_a_event;
    logic timer_b_match;
    logic timer_a_overflow;
  } pif_events1_t;
  typedef struct packed {
    logic osc_fail;
    logic nv_write_done;
    logic bus_collision;
    logic lowpower_wake;
    logic capcmp_b_event;
  } pif_events2_t;
endpackage

// ### pif_top.sv
// Added by the designer: register access over APB and the register addresses.
`timescale 1ns/1ps
`include "pif_cfg.svh"
// Summary of operation
// - Flags set on their condition regardless of any enable bit.
// - Requests reach core only with peripheral-group enable set.
// - Enable register 2 bit layout; one enables the source.
// - Unimplemented bits read zero and ignore writes; control register bits 5 down to 0 store writes and read back.
// - Flags register 1 bit layout, bits 6 down to 0.
// - Conversion-done flag sticks until software clears it.
// - Receive flag read-only, high while receive buffer holds data.
// - Transmit flag read-only, high while transmit buffer empty.
// - Sync serial flag sets on any completed port event.
// - Capture/compare A flag sets on capture or compare event.
// - Timer B match flag sticks until cleared.
// - Timer A overflow flag sticks until cleared.
// - Flags register 2 matches enable register 2 bit for bit.
// - Oscillator-fail flag sets on oscillator failure switchover.
// - Comparator flags set on any output change.
// - Nonvolatile write flag sets on write completion.
// - Bus collision flag sets on master bus collision.
// - Low-power wake flag sets on wake-up condition.
// - Capture/compare B flag sets on capture or compare event.
module pif_top
  import pif_pkg::*;
(
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire pif_events1_t EVENTS1,
  input wire pif_events2_t EVENTS2,
  input wire logic SERIAL_RX_FULL,
  input wire logic SERIAL_TX_EMPTY,
  input wire logic COMPARATOR_A_OUTPUT,
  input wire logic COMPARATOR_B_OUTPUT,
  output logic PERIPH_IRQ,
  output logic CORE_IRQ
);
  pif_state_t state_reg;
  pif_state_t state_next;
  logic wr;
  logic rd;
  logic mapped;
  logic [7:0] set1;
  logic [7:0] set2;
  logic [7:0] flags1_view;
  logic [7:0] pending;

  function automatic logic [7:0] sticky(input logic [7:0] cur, input logic [7:0] set,
                                        input logic clr_wr, input logic [7:0] wdata,
                                        input logic [7:0] mask);
    logic [7:0] v;
    v = cur;
    if (clr_wr) begin
      v = cur & wdata;
    end
    sticky = (v | set) & mask;
  endfunction

  assign wr = PSEL && PENABLE && PWRITE;
  assign rd = PSEL && !PENABLE && !PWRITE;
  assign mapped = (PADDR == `PIF_OFF_ENABLE2) || (PADDR == `PIF_OFF_FLAGS1) ||
                  (PADDR == `PIF_OFF_FLAGS2) || (PADDR == `PIF_OFF_CONTROL);
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !mapped;
  assign PRDATA = state_reg.prdata;

  // Event sets, independent of enables
  assign set1 = {1'b0, EVENTS1.conversion_done, 2'b00, EVENTS1.sync_serial_done,
                 EVENTS1.capcmp_a_event, EVENTS1.timer_b_match, EVENTS1.timer_a_overflow};
  // Comparator change detect others
  assign set2 = {EVENTS2.osc_fail, COMPARATOR_B_OUTPUT ^ state_reg.cmp_out[1],
                 COMPARATOR_A_OUTPUT ^ state_reg.cmp_out[0], EVENTS2.nv_write_done,
                 EVENTS2.bus_collision, EVENTS2.lowpower_wake, 1'b0, EVENTS2.capcmp_b_event};
  // Live status bits mirror the serial buffers
  always_comb begin
    flags1_view = state_reg.flags1_sw & `PIF_MASK_FLAGS1_SW;
    flags1_view[`PIF_BIT_RX_FULL] = SERIAL_RX_FULL;
    flags1_view[`PIF_BIT_TX_EMPTY] = SERIAL_TX_EMPTY;
  end
  assign pending = (state_reg.flags2 & state_reg.enable2);

  always_comb begin
    state_next = state_reg;
    state_next.cmp_out = {COMPARATOR_B_OUTPUT, COMPARATOR_A_OUTPUT};
    if (wr && PADDR == `PIF_OFF_ENABLE2) begin
      state_next.enable2 = PWDATA[7:0] & `PIF_MASK_ENABLE2;
    end
    if (wr && PADDR == `PIF_OFF_CONTROL) begin
      state_next.control = PWDATA[7:0];
    end
    state_next.flags1_sw = sticky(state_reg.flags1_sw, set1,
                                  wr && PADDR == `PIF_OFF_FLAGS1, PWDATA[7:0],
                                  `PIF_MASK_FLAGS1_SW);
    state_next.flags2 = sticky(state_reg.flags2, set2,
                               wr && PADDR == `PIF_OFF_FLAGS2, PWDATA[7:0],
                               `PIF_MASK_FLAGS2);
    state_next.prdata = 32'h00000000;
    if (PSEL && PENABLE) begin
      state_next.prdata = state_reg.prdata;
    end
    if (rd) begin
      case (PADDR)
        `PIF_OFF_ENABLE2: state_next.prdata = {24'h000000, state_reg.enable2};
        `PIF_OFF_FLAGS1: state_next.prdata = {24'h000000, flags1_view & `PIF_MASK_FLAGS1};
        `PIF_OFF_FLAGS2: state_next.prdata = {24'h000000, state_reg.flags2};
        `PIF_OFF_CONTROL: state_next.prdata = {24'h000000, state_reg.control};
        default: state_next.prdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      state_reg.enable2 <= `PIF_RST_ENABLE2;
      state_reg.flags1_sw <= `PIF_RST_FLAGS1;
      state_reg.flags2 <= `PIF_RST_FLAGS2;
      state_reg.control <= `PIF_RST_CONTROL;
      state_reg.prdata <= 32'h00000000;
      state_reg.cmp_out <= 2'b00;
    end else begin
      state_reg <= state_next;
    end
  end

  // Request gating
  always_comb begin
    PERIPH_IRQ = state_reg.control[`PIF_BIT_GROUP_EN] && (|pending);
    CORE_IRQ = PERIPH_IRQ && state_reg.control[`PIF_BIT_GLOBAL_EN];
  end

  // Read data captured in setup, held through access and one cycle after
  // Assertions
  sequence s_flag_write;
    PSEL && PENABLE && PWRITE && PADDR == `PIF_OFF_FLAGS2;
  endsequence

  AST_SET_WINS: assert property (@(posedge CLK) disable iff (!RESETN)
    (s_flag_write and EVENTS2.osc_fail) |=> state_reg.flags2[7])
    else $error("hardware set lost to clear");
  AST_STICKY: assert property (@(posedge CLK) disable iff (!RESETN)
    (state_reg.flags1_sw[0] && !(PSEL && PENABLE && PWRITE && PADDR == `PIF_OFF_FLAGS1))
    |=> state_reg.flags1_sw[0])
    else $error("timer flag dropped without clear");
  AST_SET_ALWAYS: assert property (@(posedge CLK) disable iff (!RESETN)
    EVENTS1.conversion_done |=> state_reg.flags1_sw[6])
    else $error("conversion flag not set");
  AST_GROUP_GATE: assert property (@(posedge CLK) disable iff (!RESETN)
    !state_reg.control[`PIF_BIT_GROUP_EN] |-> !PERIPH_IRQ)
    else $error("request passed without group enable");
  AST_UNUSED_ZERO: assert property (@(posedge CLK) disable iff (!RESETN)
    !state_reg.enable2[1] && !state_reg.flags2[1] && !state_reg.flags1_sw[7])
    else $error("unimplemented bit set");
  AST_CMP_CHANGE: assert property (@(posedge CLK) disable iff (!RESETN)
    $changed(COMPARATOR_A_OUTPUT) |=> state_reg.flags2[5])
    else $error("comparator change missed");
  AST_REQ: assert property (@(posedge CLK) disable iff (!RESETN)
    (state_reg.control[`PIF_BIT_GROUP_EN] && state_reg.flags2[0] && state_reg.enable2[0])
    |-> PERIPH_IRQ)
    else $error("request missing");
  AST_RX_VIEW: assert property (@(posedge CLK) disable iff (!RESETN)
    (PSEL && PENABLE && !PWRITE && PADDR == `PIF_OFF_FLAGS1) |->
    PRDATA[5] == $past(SERIAL_RX_FULL))
    else $error("receive flag misreported");
  AST_TX_VIEW: assert property (@(posedge CLK) disable iff (!RESETN)
    (PSEL && PENABLE && !PWRITE && PADDR == `PIF_OFF_FLAGS1) |->
    PRDATA[4] == $past(SERIAL_TX_EMPTY))
    else $error("transmit flag misreported");
endmodule

// ### pif_peri_model.sv
`timescale 1ns/1ps
module pif_peri_model
  import pif_pkg::*;
(
  input wire logic clk,
  output pif_events1_t ev1,
  output pif_events2_t ev2,
  output logic rx_full,
  output logic tx_empty,
  output logic cmp_a,
  output logic cmp_b
);
  initial begin
    ev1 = '0;
    ev2 = '0;
    {rx_full, tx_empty, cmp_a, cmp_b} = 4'h0;
  end
  // One-cycle condition pulses
  task automatic pulse(input logic [4:0] m1, input logic [4:0] m2);
    @(posedge clk);
    ev1 <= m1;
    ev2 <= m2;
    @(posedge clk);
    ev1 <= '0;
    ev2 <= '0;
  endtask
  // Buffer state and comparator output levels
  task automatic levels(input logic [3:0] v);
    @(posedge clk);
    {rx_full, tx_empty, cmp_a, cmp_b} <= v;
  endtask
endmodule

// ### pif_top_tb.sv
`timescale 1ns/1ps
`include "pif_cfg.svh"
module pif_top_tb import pif_pkg::*;;
  localparam logic [11:0] A_EN = `PIF_OFF_ENABLE2;
  localparam logic [11:0] A_F1 = `PIF_OFF_FLAGS1;
  localparam logic [11:0] A_F2 = `PIF_OFF_FLAGS2;
  localparam logic [11:0] A_CT = `PIF_OFF_CONTROL;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata, rd;
  logic pready, slverr, err, periph_irq, core_irq, rx_full, tx_empty, cmp_a, cmp_b;
  pif_events1_t ev1;
  pif_events2_t ev2;
  int n_errors = 0;
  int check_count = 0;
  int b1[5] = '{6, 3, 2, 1, 0};
  int b2[5] = '{7, 4, 3, 2, 0};
  initial begin
    forever #50 clk = ~clk;
  end
  pif_top u_pif_top(.CLK(clk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(slverr), .EVENTS1(ev1), .EVENTS2(ev2), .SERIAL_RX_FULL(rx_full),
    .SERIAL_TX_EMPTY(tx_empty), .COMPARATOR_A_OUTPUT(cmp_a), .COMPARATOR_B_OUTPUT(cmp_b),
    .PERIPH_IRQ(periph_irq), .CORE_IRQ(core_irq));
  pif_peri_model u_pif_peri_model(.clk(clk), .ev1(ev1), .ev2(ev2), .rx_full(rx_full),
    .tx_empty(tx_empty), .cmp_a(cmp_a), .cmp_b(cmp_b));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    err = slverr;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge clk);
  endtask
  task automatic rdc(input string what, input logic [11:0] a, input logic [7:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, {24'h0, exp}, rd);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    rdc("enable2", A_EN, 8'h00);
    rdc("flags1", A_F1, 8'h00);
    rdc("flags2", A_F2, 8'h00);
    apb(1'b1, A_EN, 32'hffffffff);
    rdc("enable2 mask", A_EN, 8'hfd);
    apb(1'b1, A_F2, 32'hff);
    rdc("flags2 write one", A_F2, 8'h00);
    $display("registers test done");
    for (int i = 0; i < 5; i++) begin
      u_pif_peri_model.pulse(5'(5'h10 >> i), 5'(5'h10 >> i));
      rdc("flags1 event", A_F1, 8'(8'h01 << b1[i]));
      rdc("flags2 event", A_F2, 8'(8'h01 << b2[i]));
      chk("group gate", 32'h0, {31'h0, periph_irq});
      apb(1'b1, A_F1, 32'h0);
      apb(1'b1, A_F2, 32'h0);
      rdc("flags1 clear", A_F1, 8'h00);
    end
    $display("events test done");
    u_pif_peri_model.pulse(5'h00, 5'h01);
    apb(1'b1, A_CT, 32'h40);
    chk("periph irq", 32'h1, {31'h0, periph_irq});
    chk("core irq off", 32'h0, {31'h0, core_irq});
    apb(1'b1, A_CT, 32'hc0);
    chk("core irq", 32'h1, {31'h0, core_irq});
    apb(1'b1, A_EN, 32'hfc);
    chk("irq masked", 32'h0, {31'h0, periph_irq});
    apb(1'b1, A_F2, 32'h0);
    $display("request test done");
    u_pif_peri_model.levels(4'hf);
    rdc("rx tx live", A_F1, 8'h30);
    rdc("cmp rise", A_F2, 8'h60);
    apb(1'b1, A_F1, 32'h0);
    apb(1'b1, A_F2, 32'h0);
    rdc("rx tx read only", A_F1, 8'h30);
    u_pif_peri_model.levels(4'h0);
    rdc("rx tx gone", A_F1, 8'h00);
    rdc("cmp fall", A_F2, 8'h60);
    $display("levels test done");
    fork
      apb(1'b1, A_F2, 32'h0);
      begin
        @(posedge clk);
        u_pif_peri_model.pulse(5'h00, 5'h10);
      end
    join
    rdc("set beats clear", A_F2, 8'h80);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    $display("corner test done");
    results;
  end
  initial begin
    repeat (3000) @(posedge clk);
    n_errors++;
    results;
  end
endmodule
